// file: hrap_pkg.sv
package hrap_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam int AW = 11;
  localparam int DW = 8;
  localparam logic [10:0] SOFT_RESET_OFF = 11'h004;
  localparam logic [10:0] LINE_STD_OFF = 11'h020;
  localparam logic [10:0] TX_CFG0_OFF = 11'h022;
  localparam logic [10:0] RX_CFG0_OFF = 11'h028;
  // indirect blocks: 0 transmit payload, 1 receive payload,
  // 2 receive signaling buffer
  localparam int NBLK = 3;
  localparam logic [2:0][10:0] IND_STAT_OFF = {11'h0D3, 11'h0CD, 11'h0C8};
  localparam logic [2:0][10:0] IND_CTRL_OFF = {11'h0D4, 11'h0CE, 11'h0C9};
  localparam logic [2:0][10:0] IND_DATA_OFF = {11'h0D5, 11'h0CF, 11'h0CA};

  // ------------------------------------------------------------------
  // field layout and reset values
  // ------------------------------------------------------------------
  localparam int T_OFF_BIT = 4;
  localparam int R_OFF_BIT = 4;
  localparam int BUSY_BIT = 0;
  localparam int DIR_BIT = 7;
  localparam int IND_AW = 7;
  localparam logic [7:0] LINE_STD_RST = 8'h00;
  localparam logic [7:0] TX_CFG0_RST = 8'h00;
  localparam logic [7:0] RX_CFG0_RST = 8'h00;
  localparam logic [7:0] IND_CTRL_RST = 8'h00;
  localparam logic [7:0] IND_DATA_RST = 8'h00;

  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int CLK_PERIOD_NS = 5;
  localparam int READY_TIME_US = 2000;
  localparam int READY_CYC = READY_TIME_US * CLK_MHZ;
  localparam int IND_LIMIT_NS = 4000;
  localparam int IND_MAX_CYC = IND_LIMIT_NS / CLK_PERIOD_NS;
  localparam int RDY_CW = 20;
  localparam int SPI_CMD_BITS = 16;
  localparam int SPI_ALL_BITS = 24;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } hrap_req_t;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_ISSUE = 2'b01,
    ENG_WAIT = 2'b11
  } hrap_eng_t;

endpackage : hrap_pkg

// file: hrap_mem.sv
`timescale 1ns/10ps
module hrap_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // access
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata_r
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem[addr];
    end
  end
endmodule : hrap_mem

// file: hrap_spi.sv
`timescale 1ns/10ps
module hrap_spi (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // synchronised serial pins
  input wire logic cs_n_s,
  input wire logic sclk_s,
  input wire logic sdi_s,
  // register side
  output hrap_pkg::hrap_req_t req_r,
  input wire logic [7:0] rdata,
  // serial data out
  output logic sdo_r,
  output logic sdo_oe_r
);
  import hrap_pkg::*;

  logic sclk_d_r;
  logic [4:0] cnt_r;
  logic [15:0] sh_r;
  logic rd_r;
  logic [AW-1:0] addr_r;
  logic [7:0] osh_r;

  wire rise = sclk_s & ~sclk_d_r;
  wire fall = ~sclk_s & sclk_d_r;
  wire [15:0] word = {sh_r[14:0], sdi_s};
  wire cmd_done = rise & (cnt_r == 5'(SPI_CMD_BITS - 1));
  wire dat_done = rise & (cnt_r == 5'(SPI_ALL_BITS - 1)) & ~rd_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_r <= 1'b0;
      cnt_r <= '0;
      sh_r <= '0;
      rd_r <= 1'b0;
      addr_r <= '0;
    end else begin
      sclk_d_r <= sclk_s;
      if (cs_n_s) begin
        cnt_r <= '0;
      end else if (rise) begin
        sh_r <= word;
        if (cnt_r != 5'(SPI_ALL_BITS)) begin
          cnt_r <= cnt_r + 5'd1;
        end
        if (cmd_done) begin
          rd_r <= sh_r[14];
          addr_r <= word[AW-1:0];
        end
      end
    end
  end

  // one request pulse per transaction; extra clocks are ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_r <= '0;
    end else begin
      req_r <= '0;
      if (!cs_n_s && cmd_done && sh_r[14]) begin
        req_r.valid <= 1'b1;
        req_r.addr <= word[AW-1:0];
      end else if (!cs_n_s && dat_done) begin
        req_r.valid <= 1'b1;
        req_r.write <= 1'b1;
        req_r.addr <= addr_r;
        req_r.wdata <= word[7:0];
      end
    end
  end

  // read data leaves msb first, changing on falling clock edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
      osh_r <= '0;
    end else if (cs_n_s) begin
      sdo_oe_r <= 1'b0;
    end else if (fall && rd_r && cnt_r == 5'(SPI_CMD_BITS)) begin
      sdo_r <= rdata[7];
      osh_r <= {rdata[6:0], 1'b0};
      sdo_oe_r <= 1'b1;
    end else if (fall && rd_r && cnt_r > 5'(SPI_CMD_BITS)) begin
      sdo_r <= osh_r[7];
      osh_r <= {osh_r[6:0], 1'b0};
    end
  end
endmodule : hrap_spi

// file: hrap_top.sv
// How it works
// - defaults after reset, access after 2 ms
// - soft reset write restores defaults, 2 ms wait
// - line standard register survives soft reset
// - receive power-down drives receive output low
// - transmit power-down floats transmit output
// - select pin high gives serial port
// - select low gives parallel, style pin strobes
// - chip select edges frame serial transaction
// - command and address sampled on rising clock
// - direction msb, address bits across two bytes
// - direction one reads, zero writes
// - read data changes on falling clock edges
// - per-channel registers reached only indirectly
// - indirect access completes within 4 us
`timescale 1ns/10ps
module hrap_top #(
  parameter int READY_CYC = hrap_pkg::READY_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // mode straps
  input wire logic serial_host_select,
  input wire logic parallel_bus_style_select,
  // serial host port
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // parallel host port
  input wire logic pcs_n,
  input wire logic bus_strobe_n,
  input wire logic rw_wr_n,
  input wire logic [7:0] paddr,
  input wire logic [7:0] pdata_in,
  output logic [7:0] pdata_out,
  output logic pdata_oe,
  // line paths
  input wire logic tx_data_in,
  output logic tx_line_out,
  output logic tx_line_oe,
  input wire logic rx_data_in,
  output logic rx_path_out,
  // status
  output logic [7:0] line_standard,
  output logic access_ready
);
  import hrap_pkg::*;

  // ------------------------------------------------------------------
  // reset release and pin synchronisers
  // ------------------------------------------------------------------
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [23:0] pin_a_r;
  logic [23:0] pin_b_r;
  logic [1:0] line_a_r;
  logic [1:0] line_b_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // every pin sees two flops before any logic looks at it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // idle levels: serial clock low, selects and strobes high, so the
      // edge detectors see no false edge after reset
      pin_a_r <= 24'hEFFFFF;
      pin_b_r <= 24'hEFFFFF;
      line_a_r <= 2'b00;
      line_b_r <= 2'b00;
    end else begin
      pin_a_r <= {serial_host_select, parallel_bus_style_select, cs_n,
                  sclk, sdi, pcs_n, bus_strobe_n, rw_wr_n, paddr,
                  pdata_in};
      pin_b_r <= pin_a_r;
      line_a_r <= {tx_data_in, rx_data_in};
      line_b_r <= line_a_r;
    end
  end

  wire spi_mode = pin_b_r[23];
  wire style_hi = pin_b_r[22];
  wire cs_n_s = pin_b_r[21] | ~spi_mode;
  wire sclk_s = pin_b_r[20];
  wire sdi_s = pin_b_r[19];
  wire pcs_n_s = pin_b_r[18] | spi_mode;
  wire strobe_n_s = pin_b_r[17];
  wire rw_s = pin_b_r[16];
  wire [7:0] paddr_s = pin_b_r[15:8];
  wire [7:0] pdata_s = pin_b_r[7:0];

  // ------------------------------------------------------------------
  // serial front end
  // ------------------------------------------------------------------
  hrap_req_t spi_req;
  logic [7:0] rdata_r;

  hrap_spi u_spi (
    .clk(clk),
    .rst_n(rst_n),
    .cs_n_s(cs_n_s),
    .sclk_s(sclk_s),
    .sdi_s(sdi_s),
    .req_r(spi_req),
    .rdata(rdata_r),
    .sdo_r(sdo),
    .sdo_oe_r(sdo_oe)
  );

  // ------------------------------------------------------------------
  // parallel front end
  // ------------------------------------------------------------------
  // style low: strobe plus read/write level; style high: split strobes
  wire p_rd = ~pcs_n_s & ~strobe_n_s & (style_hi | rw_s);
  wire p_wr = ~pcs_n_s & ~rw_s & (style_hi | ~strobe_n_s);
  logic p_rd_d_r;
  logic p_wr_d_r;
  hrap_req_t par_req;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      p_rd_d_r <= 1'b0;
      p_wr_d_r <= 1'b0;
      pdata_out <= '0;
      pdata_oe <= 1'b0;
    end else begin
      p_rd_d_r <= p_rd;
      p_wr_d_r <= p_wr;
      pdata_out <= rdata_r;
      pdata_oe <= p_rd & p_rd_d_r;
    end
  end

  assign par_req.valid = (p_rd & ~p_rd_d_r) | (p_wr & ~p_wr_d_r);
  assign par_req.write = p_wr & ~p_wr_d_r;
  assign par_req.addr = {3'b000, paddr_s};
  assign par_req.wdata = pdata_s;

  // ------------------------------------------------------------------
  // common register access
  // ------------------------------------------------------------------
  logic ready_r;
  logic [RDY_CW-1:0] rdy_cnt_r;
  logic srst_r;
  logic [7:0] line_std_r;
  logic [7:0] tx_cfg_r;
  logic [7:0] rx_cfg_r;
  logic [NBLK-1:0] busy;
  logic [NBLK-1:0][7:0] stat_rd;
  logic [NBLK-1:0][7:0] ctrl_rd;
  logic [NBLK-1:0][7:0] data_rd;

  // accesses before the settle time has run out are dropped
  wire hrap_req_t req = spi_mode ? spi_req : par_req;
  wire acc = req.valid & ready_r;
  wire wr = acc & req.write;
  wire rd = acc & ~req.write;
  wire hit_srst = req.addr == SOFT_RESET_OFF;
  wire hit_std = req.addr == LINE_STD_OFF;
  wire hit_tx = req.addr == TX_CFG0_OFF;
  wire hit_rx = req.addr == RX_CFG0_OFF;

  // soft reset register is write only and reads as zero
  wire [7:0] rd_val = ({8{hit_std}} & line_std_r)
                    | ({8{hit_tx}} & tx_cfg_r)
                    | ({8{hit_rx}} & rx_cfg_r)
                    | stat_rd[0] | stat_rd[1] | stat_rd[2]
                    | ctrl_rd[0] | ctrl_rd[1] | ctrl_rd[2]
                    | data_rd[0] | data_rd[1] | data_rd[2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
      srst_r <= 1'b0;
    end else begin
      srst_r <= wr & hit_srst;
      if (rd) begin
        rdata_r <= rd_val;
      end
    end
  end

  // settle timer restarts on hardware and software reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_cnt_r <= '0;
      ready_r <= 1'b0;
    end else if (srst_r) begin
      rdy_cnt_r <= '0;
      ready_r <= 1'b0;
    end else if (!ready_r) begin
      rdy_cnt_r <= rdy_cnt_r + 1'b1;
      if (rdy_cnt_r == RDY_CW'(READY_CYC - 1)) begin
        ready_r <= 1'b1;
      end
    end
  end

  // line standard only returns to default on hardware reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_std_r <= LINE_STD_RST;
    end else if (wr && hit_std) begin
      line_std_r <= req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_cfg_r <= TX_CFG0_RST;
      rx_cfg_r <= RX_CFG0_RST;
    end else if (srst_r) begin
      tx_cfg_r <= TX_CFG0_RST;
      rx_cfg_r <= RX_CFG0_RST;
    end else begin
      if (wr && hit_tx) begin
        tx_cfg_r <= req.wdata;
      end
      if (wr && hit_rx) begin
        rx_cfg_r <= req.wdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // indirect access engines, one per block
  // ------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NBLK; g++) begin : g_blk
      hrap_eng_t st_r;
      logic [7:0] ctrl_r;
      logic [7:0] data_r;
      logic [7:0] mem_rdata;
      wire hit_st = req.addr == IND_STAT_OFF[g];
      wire hit_ct = req.addr == IND_CTRL_OFF[g];
      wire hit_dt = req.addr == IND_DATA_OFF[g];
      wire go = wr & hit_ct & (st_r == ENG_IDLE);
      wire mem_we = (st_r == ENG_ISSUE) & ~ctrl_r[DIR_BIT];

      assign busy[g] = st_r != ENG_IDLE;
      assign stat_rd[g] = {8{hit_st}} & (8'(busy[g]) << BUSY_BIT);
      assign ctrl_rd[g] = {8{hit_ct}} & ctrl_r;
      assign data_rd[g] = {8{hit_dt}} & data_r;

      // per-channel storage is only visible through this engine
      hrap_mem #(
        .AW(IND_AW),
        .DW(8)
      ) u_mem (
        .clk(clk),
        .rst_n(rst_n),
        .we(mem_we),
        .addr(ctrl_r[IND_AW-1:0]),
        .wdata(data_r),
        .rdata_r(mem_rdata)
      );

      // a control write while busy is refused; issue, wait, done
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          st_r <= ENG_IDLE;
          ctrl_r <= IND_CTRL_RST;
          data_r <= IND_DATA_RST;
        end else if (srst_r) begin
          st_r <= ENG_IDLE;
          ctrl_r <= IND_CTRL_RST;
          data_r <= IND_DATA_RST;
        end else begin
          case (st_r)
            ENG_IDLE: begin
              if (go) begin
                ctrl_r <= req.wdata;
                st_r <= ENG_ISSUE;
              end else if (wr && hit_dt) begin
                data_r <= req.wdata;
              end
            end
            ENG_ISSUE: begin
              st_r <= ENG_WAIT;
            end
            ENG_WAIT: begin
              if (ctrl_r[DIR_BIT]) begin
                data_r <= mem_rdata;
              end
              st_r <= ENG_IDLE;
            end
            default: begin
              st_r <= ENG_IDLE;
            end
          endcase
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // line path power-down and status outputs
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_line_out <= 1'b0;
      tx_line_oe <= 1'b0;
      rx_path_out <= 1'b0;
      line_standard <= LINE_STD_RST;
      access_ready <= 1'b0;
    end else begin
      tx_line_out <= line_b_r[1];
      tx_line_oe <= ~tx_cfg_r[T_OFF_BIT];
      rx_path_out <= line_b_r[0] & ~rx_cfg_r[R_OFF_BIT];
      line_standard <= line_std_r;
      access_ready <= ready_r;
    end
  end
endmodule : hrap_top

// file: hrap_top_properties.sv
`timescale 1ns/10ps
module hrap_top_properties #(
  parameter int READY_CYC = hrap_pkg::READY_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // watched pins
  input wire logic serial_host_select,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic pcs_n,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic pdata_oe,
  input wire logic rx_data_in,
  input wire logic rx_path_out,
  input wire logic [7:0] line_standard,
  input wire logic access_ready
);
  // ------------------------------------------------------------------
  // settle-time counter
  // ------------------------------------------------------------------
  logic [31:0] low_cnt_r;
  logic [31:0] low_cnt_nxt;
  assign low_cnt_nxt = access_ready ? 32'h0 : low_cnt_r + 32'h1;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_r <= 32'h0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
    end
  end

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_sdo_only_serial; !serial_host_select [*4] |-> !sdo_oe; endproperty
  a_sdo_only_serial: assert property (p_sdo_only_serial)
    else $error("serial output driven in parallel mode");
  property p_pdata_only_par; serial_host_select [*4] |-> !pdata_oe; endproperty
  a_pdata_only_par: assert property (p_pdata_only_par)
    else $error("parallel data driven in serial mode");
  property p_oe_in_frame; $rose(sdo_oe) |-> !cs_n; endproperty
  a_oe_in_frame: assert property (p_oe_in_frame)
    else $error("serial output enabled outside a frame");
  property p_oe_drop; cs_n [*8] |-> !sdo_oe; endproperty
  a_oe_drop: assert property (p_oe_drop)
    else $error("serial output held after frame end");
  property p_sdo_on_fall;
    sdo_oe && !cs_n && $changed(sdo) |-> !sclk && !$past(sclk);
  endproperty
  a_sdo_on_fall: assert property (p_sdo_on_fall)
    else $error("read data moved while serial clock high");
  property p_ready_wait;
    $rose(access_ready) |-> low_cnt_r >= 32'(READY_CYC - 1);
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("access allowed before settle time");
  property p_ready_bound;
    !access_ready |-> low_cnt_r <= 32'(READY_CYC + 8);
  endproperty
  a_ready_bound: assert property (p_ready_bound)
    else $error("access not allowed after settle time");
  property p_soft_keep_std; $fell(access_ready) |-> $stable(line_standard);
  endproperty
  a_soft_keep_std: assert property (p_soft_keep_std)
    else $error("line standard changed by soft reset");
  property p_soft_in_frame; $fell(access_ready) |-> !cs_n || !pcs_n; endproperty
  a_soft_in_frame: assert property (p_soft_in_frame)
    else $error("ready dropped without a host access");
  property p_rx_gate;
    rx_path_out |-> $past(rx_data_in, 2) || $past(rx_data_in, 3)
      || $past(rx_data_in, 4);
  endproperty
  a_rx_gate: assert property (p_rx_gate)
    else $error("receive output high without receive data");

  c_read: cover property ($rose(sdo_oe));
  c_soft: cover property ($fell(access_ready));
  c_par: cover property ($rose(pdata_oe));
endmodule : hrap_top_properties

bind hrap_top hrap_top_properties #(.READY_CYC(READY_CYC)) u_props (
  .clk(clk), .arst_n(arst_n), .serial_host_select(serial_host_select),
  .cs_n(cs_n), .sclk(sclk), .pcs_n(pcs_n), .sdo(sdo), .sdo_oe(sdo_oe),
  .pdata_oe(pdata_oe), .rx_data_in(rx_data_in), .rx_path_out(rx_path_out),
  .line_standard(line_standard), .access_ready(access_ready)
);

// file: hrap_host_model.sv
`timescale 1ns/10ps
module hrap_host_model (
  // clock
  input wire logic clk,
  // serial pins
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end

  // ------------------------------------------------------------------
  // one framed transfer; serial clock stands still between frames
  // ------------------------------------------------------------------
  task automatic frame(input logic [23:0] word, input int n,
                       output logic [7:0] q);
    q = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi <= word[23 - i];
      repeat (16) @(posedge clk);
      sclk <= 1'b1;
      // sampled late in the low phase, well after the device moved it
      if (i >= 16) begin
        q = {q[6:0], sdo};
      end
      repeat (16) @(posedge clk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    cs_n <= 1'b1;
    sdi <= ~sdi;
    repeat (8) @(posedge clk);
  endtask : frame
endmodule : hrap_host_model

// file: tb_host_register_access_port.sv
`timescale 1ns/10ps
module tb_host_register_access_port;
  import hrap_pkg::*;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  localparam int RDY = 50;
  logic clk = 1'b0;
  logic arst_n, serial_host_select, parallel_bus_style_select;
  logic cs_n, sclk, sdi, sdo, sdo_oe, pcs_n, bus_strobe_n, rw_wr_n;
  logic [7:0] paddr, pdata_in, pdata_out, line_standard, q;
  logic pdata_oe, tx_data_in, tx_line_out, tx_line_oe;
  logic rx_data_in, rx_path_out, access_ready;
  int num_errors = 0;
  int num_checks = 0;
  // address, write data, expected read back
  logic [26:0] rows [8] = '{
    {11'h022, 8'h5A, 8'h5A}, {11'h028, 8'hA5, 8'hA5},
    {11'h020, 8'h3C, 8'h3C}, {11'h0CA, 8'h11, 8'h11},
    {11'h0CF, 8'h22, 8'h22}, {11'h0C8, 8'hFF, 8'h00},
    {11'h0FF, 8'h77, 8'h00}, {11'h400, 8'h66, 8'h00}};

  always #2.5 clk = ~clk;

  // a released output shows the inverse, so a read outside oe fails
  hrap_host_model u_host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .sdo(sdo_oe ? sdo : ~sdo));
  hrap_top #(.READY_CYC(RDY)) dut_u (.clk(clk), .arst_n(arst_n),
    .serial_host_select(serial_host_select),
    .parallel_bus_style_select(parallel_bus_style_select),
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .pcs_n(pcs_n), .bus_strobe_n(bus_strobe_n), .rw_wr_n(rw_wr_n),
    .paddr(paddr), .pdata_in(pdata_in), .pdata_out(pdata_out),
    .pdata_oe(pdata_oe), .tx_data_in(tx_data_in), .tx_line_out(tx_line_out),
    .tx_line_oe(tx_line_oe), .rx_data_in(rx_data_in),
    .rx_path_out(rx_path_out), .line_standard(line_standard),
    .access_ready(access_ready));

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task end_of_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [10:0] a, input logic [7:0] d);
    logic [7:0] junk;
    u_host.frame({1'b0, 4'h0, a, d}, 24, junk);
  endtask : wr

  task rd(input logic [10:0] a, output logic [7:0] d);
    u_host.frame({1'b1, 4'h0, a, 8'h00}, 24, d);
  endtask : rd

  task par(input logic style, input logic wr_en, input logic [7:0] a,
           input logic [7:0] d, output logic [7:0] r);
    parallel_bus_style_select <= style;
    paddr <= a;
    pdata_in <= d;
    rw_wr_n <= style | ~wr_en;
    pcs_n <= 1'b0;
    repeat (4) @(posedge clk);
    if (style & wr_en) begin
      rw_wr_n <= 1'b0;
    end else begin
      bus_strobe_n <= 1'b0;
    end
    repeat (8) @(posedge clk);
    r = pdata_out;
    if (!wr_en) begin
      chk({7'h0, pdata_oe}, 8'h01);
    end
    pcs_n <= 1'b1;
    bus_strobe_n <= 1'b1;
    rw_wr_n <= 1'b1;
    pdata_in <= ~d;
    repeat (4) @(posedge clk);
  endtask : par

  task wait_ready;
    int n;
    n = 0;
    while (access_ready !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      num_errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, access_ready, 1'b1);
      end_of_test;
    end else begin
      repeat (4) @(posedge clk);
    end
  endtask : wait_ready

  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    end_of_test;
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    serial_host_select = 1'b1;
    parallel_bus_style_select = 1'b0;
    pcs_n = 1'b1;
    bus_strobe_n = 1'b1;
    rw_wr_n = 1'b1;
    paddr = 8'h00;
    pdata_in = 8'h00;
    tx_data_in = 1'b0;
    rx_data_in = 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    wait_ready;
    chk(line_standard, LINE_STD_RST);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][26:16], rows[i][15:8]);
      rd(rows[i][26:16], q);
      chk(q, rows[i][7:0]);
    end
    $display("test rows done");
    wr(SOFT_RESET_OFF, 8'h00);
    chk({7'h0, access_ready}, 8'h00);
    wait_ready;
    rd(LINE_STD_OFF, q);
    chk(q, 8'h3C);
    rd(TX_CFG0_OFF, q);
    chk(q, TX_CFG0_RST);
    rd(IND_DATA_OFF[1], q);
    chk(q, IND_DATA_RST);
    $display("test soft reset done");
    for (int b = 0; b < NBLK; b++) begin
      rd(IND_STAT_OFF[b], q);
      chk(8'(q[BUSY_BIT]), 8'h00);
      wr(IND_DATA_OFF[b], 8'hC0 + 8'(b));
      wr(IND_CTRL_OFF[b], 8'h05 + 8'(b));
      rd(IND_STAT_OFF[b], q);
      chk(8'(q[BUSY_BIT]), 8'h00);
      wr(IND_DATA_OFF[b], 8'h00);
      wr(IND_CTRL_OFF[b], 8'h85 + 8'(b));
      rd(IND_STAT_OFF[b], q);
      chk(8'(q[BUSY_BIT]), 8'h00);
      rd(IND_CTRL_OFF[b], q);
      chk(q, 8'h85 + 8'(b));
      rd(IND_DATA_OFF[b], q);
      chk(q, 8'hC0 + 8'(b));
    end
    $display("test indirect done");
    rx_data_in <= 1'b1;
    tx_data_in <= 1'b1;
    wr(RX_CFG0_OFF, 8'h00);
    wr(TX_CFG0_OFF, 8'h00);
    chk({5'h0, tx_line_out, rx_path_out, tx_line_oe}, 8'h07);
    wr(RX_CFG0_OFF, 8'h01 << R_OFF_BIT);
    wr(TX_CFG0_OFF, 8'h01 << T_OFF_BIT);
    chk({6'h0, rx_path_out, tx_line_oe}, 8'h00);
    $display("test power down done");
    u_host.frame({1'b0, 4'h0, TX_CFG0_OFF, 8'hFF}, 20, q);
    rd(TX_CFG0_OFF, q);
    chk(q, 8'h01 << T_OFF_BIT);
    $display("test short frame done");
    serial_host_select <= 1'b0;
    repeat (8) @(posedge clk);
    par(1'b0, 1'b1, TX_CFG0_OFF[7:0], 8'h3C, q);
    par(1'b0, 1'b0, TX_CFG0_OFF[7:0], 8'h00, q);
    chk(q, 8'h3C);
    par(1'b1, 1'b1, RX_CFG0_OFF[7:0], 8'h81, q);
    par(1'b1, 1'b0, RX_CFG0_OFF[7:0], 8'h00, q);
    chk(q, 8'h81);
    serial_host_select <= 1'b1;
    repeat (8) @(posedge clk);
    rd(TX_CFG0_OFF, q);
    chk(q, 8'h3C);
    $display("test parallel done");
    arst_n <= 1'b0;
    repeat (20) @(posedge clk);
    chk({access_ready, sdo_oe, pdata_oe, tx_line_oe, 4'h0}, 8'h00);
    arst_n <= 1'b1;
    wait_ready;
    chk(line_standard, LINE_STD_RST);
    rd(RX_CFG0_OFF, q);
    chk(q, RX_CFG0_RST);
    $display("test hardware reset done");
    end_of_test;
  end
endmodule : tb_host_register_access_port
